/* File: vic_pkg.sv */
// Purpose: Constants and types for the vectored priority interrupt controller
// Assumes: AHB-Lite word access, 32 sources, 8 priority levels
// Notes:   Register offsets are byte addresses inside a 4 KB window
package vic_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int VIC_NSRC = 32;
  localparam int VIC_STACK_DEPTH = 8;
  localparam int VIC_EXT_BASE = 29;      // External pins feed sources 29..31
  localparam int VIC_PERIPH_HI = 28;     // Peripheral lines feed sources 2..28
  localparam logic [31:0] VIC_EXT_SRC_MASK = 32'hE000_0001;
  localparam logic [4:0] VIC_SRC_FAST = 5'h00;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] VIC_SMR_BASE = 12'h000;   // source_mode_reg 0..31
  localparam logic [11:0] VIC_SVR_BASE = 12'h080;   // source_vector_reg 0..31
  localparam logic [11:0] VIC_IVR = 12'h100;        // vector_readout_reg
  localparam logic [11:0] VIC_FVR = 12'h104;        // fast_vector_readout_reg
  localparam logic [11:0] VIC_ISR = 12'h108;        // current source number
  localparam logic [11:0] VIC_IPR = 12'h10C;        // pending image
  localparam logic [11:0] VIC_IMR = 12'h110;        // enable mask
  localparam logic [11:0] VIC_CISR = 12'h114;       // request line image
  localparam logic [11:0] VIC_IECR = 12'h120;
  localparam logic [11:0] VIC_IDCR = 12'h124;
  localparam logic [11:0] VIC_ICCR = 12'h128;
  localparam logic [11:0] VIC_ISCR = 12'h12C;
  localparam logic [11:0] VIC_EOICR = 12'h130;      // end_of_service_cmd
  localparam logic [11:0] VIC_SPU = 12'h134;        // spurious vector
  localparam logic [11:0] VIC_DCR = 12'h138;        // protect / general mask
  localparam logic [11:0] VIC_FFER = 12'h140;
  localparam logic [11:0] VIC_FFDR = 12'h144;
  localparam logic [11:0] VIC_FFSR = 12'h148;
  localparam logic [11:0] VIC_TABLE_END = 12'h100;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int VIC_PRIO_LSB = 0;       // priority_level_field [2:0]
  localparam int VIC_TYPE_LSB = 5;       // trigger_type_field [6:5]
  localparam int VIC_DCR_PROTECT = 0;
  localparam int VIC_DCR_GMASK = 1;
  localparam logic [1:0] VIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] VIC_HSIZE_WORD = 3'h2;

  // Trigger type: bit1 selects high/rising on pins, bit0 selects edge
  typedef enum logic [1:0] {
    VIC_TRIG_LOW_LEVEL = 2'b00,
    VIC_TRIG_FALL_EDGE = 2'b01,
    VIC_TRIG_HIGH_LEVEL = 2'b10,
    VIC_TRIG_RISE_EDGE = 2'b11
  } vic_trig_t;

  typedef struct packed {
    logic [2:0] prio;
    logic [1:0] trig;
  } vic_mode_t;

  typedef struct packed {
    logic [4:0] src;
    logic [2:0] prio;
  } vic_entry_t;

endpackage

/* File: vectored_priority_interrupt_ctrl.sv */
// Purpose: Vectored 8-level priority interrupt controller, AHB-Lite slave
// Assumes: sys_clk always running; peripheral lines synchronous to sys_clk
// Notes:   Reads take one wait state so a preceding write is always visible
//
// Contract
// (R1) Thirty-two sources, each maskable and vectored, eight priority levels.
// (R2) Drives a fast request and a normal request to the processor.
// (R3) Higher-priority source raises normal request during lower-priority service.
// (R4) Internal sources select level-sensitive or edge-triggered.
// (R5) Pin sources select rising, falling, high level or low level.
// (R6) Fast forcing routes a chosen source to the fast request.
// (R7) Source 0 is the fast interrupt pin.
// (R8) Source 1 is the OR of system peripheral interrupt lines.
// (R9) Sources 2..31 are peripheral outputs or external pins.
// (R10) Priority arbitration covers sources 1..31 and drives normal request.
// (R11) Each source holds a 32-bit software handler vector.
// (R12) Vector readout returns the vector of the selected current source.
// (R13) Protect mode stops reads from having side effects.
// (R14) Always clocked; no power-management gating.
// (R15) Either request asserting wakes the processor from idle.
// (R16) General mask wakes the processor without asserting request lines.
// (R17) Three external pin sources besides the fast pin.
// (R18) Source index equals peripheral identifier everywhere.
// (R19) Priority 7 is highest, 0 lowest.
// (R20) Equal priority ties go to the lowest source number.
// (R21) Vector read clears selected edge source unless fast forced; fast read clears 0.
// (R22) Eight-entry stack saves source and priority; end-of-service restores.
// (R23) Requests are active low; pins synchronised before detection.
// (R24) Edge pending latches until cleared; level pending follows input.
`timescale 1ns/1ps

module vectored_priority_interrupt_ctrl
  import vic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fastIntPin,
  input wire logic systemSource,
  input wire logic [VIC_PERIPH_HI:2] peripheralSourceIds,
  input wire logic [2:0] extIntPins,
  output logic fastReqOutN,
  output logic normalReqOutN,
  output logic wakeOut
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic [31:0] prevCond;
    logic [31:0] edgeLatch;
    logic [31:0] imr;
    logic [31:0] ffsr;
    vic_mode_t [31:0] smr;
    logic [31:0][31:0] svr;
    logic [31:0] spu;
    vic_entry_t [7:0] stack;
    logic [3:0] depth;
    logic protect;
    logic genMask;
    logic dpValid;
    logic dpWrite;
    logic rdDone;
    logic [11:0] dpAddr;
    logic [31:0] rdata;
    logic fastReqN;
    logic normReqN;
    logic wake;
  } vic_state_t;

  vic_state_t st;
  vic_state_t next_st;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Highest priority wins; scanning downward lets lower numbers take ties
  function automatic logic [8:0] vic_pick(input logic [31:0] cand,
                                          input vic_mode_t [31:0] mode);
    logic found;
    logic [4:0] src;
    logic [2:0] prio;
    found = 1'b0;
    src = 5'h00;
    prio = 3'h0;
    for (int i = VIC_NSRC - 1; i >= 1; i--) begin  // [R10]
      if (cand[i] && (!found || mode[i].prio >= prio)) begin  // [R19] [R20]
        found = 1'b1;
        src = 5'(i);
        prio = mode[i].prio;
      end
    end
    return {found, src, prio};
  endfunction

  function automatic logic vic_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Source conditioning
  // ----------------------------------------------------------------
  logic [31:0] rawSrc;
  logic [31:0] cond;
  logic [31:0] edgeMode;
  logic [31:0] pending;
  logic [31:0] active;

  always_comb begin
    rawSrc = '0;
    rawSrc[VIC_SRC_FAST] = st.pinSync[0];  // [R7] [R23]
    rawSrc[1] = systemSource;  // [R8]
    rawSrc[VIC_PERIPH_HI:2] = peripheralSourceIds;  // [R9] [R18]
    rawSrc[VIC_NSRC-1:VIC_EXT_BASE] = st.pinSync[3:1];  // [R17]
  end

  genvar g;
  generate
    for (g = 0; g < VIC_NSRC; g++) begin : gSrc
      if (VIC_EXT_SRC_MASK[g]) begin : gPin
        // Pins: polarity from the type's upper bit
        assign cond[g] = st.smr[g].trig[1] ? rawSrc[g] : ~rawSrc[g];  // [R5]
      end else begin : gInt
        assign cond[g] = rawSrc[g];  // [R4]
      end
      assign edgeMode[g] = st.smr[g].trig[0];
      assign pending[g] = edgeMode[g] ? st.edgeLatch[g] : cond[g];  // [R24]
    end
  endgenerate

  assign active = pending & st.imr;  // [R1]

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [8:0] pick;
  logic candFound;
  logic [4:0] candSrc;
  logic [2:0] candPrio;
  vic_entry_t curEntry;
  logic inService;
  logic normalReq;
  logic fastReq;

  always_comb begin
    pick = vic_pick(active & ~st.ffsr, st.smr);
    candFound = pick[8];
    candSrc = pick[7:3];
    candPrio = pick[2:0];
    inService = st.depth != 4'h0;
    curEntry = inService ? st.stack[3'(st.depth - 4'h1)] : '0;
    // Only a strictly higher level may interrupt the current service
    normalReq = candFound && (!inService || candPrio > curEntry.prio);  // [R3]
    fastReq = active[VIC_SRC_FAST] || |(active & st.ffsr);  // [R6]
  end

  // ----------------------------------------------------------------
  // Bus and next state
  // ----------------------------------------------------------------
  logic takeAddr;
  logic doWrite;
  logic doRead;
  logic ivrAck;
  logic fvrAck;
  logic [4:0] slot;
  logic [31:0] rd;

  always_comb begin
    next_st = st;
    takeAddr = hsel && htrans == VIC_HTRANS_NONSEQ && hready && hsize == VIC_HSIZE_WORD;
    doWrite = st.dpValid && st.dpWrite;
    doRead = st.dpValid && !st.dpWrite && !st.rdDone;
    slot = st.dpAddr[6:2];
    // In protect mode the entry side effects move from the read to a write
    ivrAck = vic_is(st.dpAddr, VIC_IVR) &&
             (st.protect ? doWrite : doRead);  // [R13]
    fvrAck = vic_is(st.dpAddr, VIC_FVR) && doRead && !st.protect;  // [R13]
    rd = '0;

    // Pin synchroniser: the first stage feeds only the second
    next_st.pinMeta = {extIntPins, fastIntPin};
    next_st.pinSync = st.pinMeta;  // [R23]
    next_st.prevCond = cond;
    for (int i = 0; i < VIC_NSRC; i++) begin
      if (!edgeMode[i]) begin
        next_st.edgeLatch[i] = 1'b0;
      end
    end

    // Read mux
    if (st.dpAddr < VIC_SVR_BASE) begin
      rd = {25'h0, st.smr[slot].trig, 2'h0, st.smr[slot].prio};
    end else if (st.dpAddr < VIC_TABLE_END) begin
      rd = st.svr[slot];  // [R11]
    end else begin
      unique case (st.dpAddr)
        VIC_IVR: rd = candFound ? st.svr[candSrc] : st.spu;  // [R12]
        VIC_FVR: rd = fastReq ? st.svr[VIC_SRC_FAST] : st.spu;
        VIC_ISR: rd = {27'h0, curEntry.src};
        VIC_IPR: rd = pending;
        VIC_IMR: rd = st.imr;
        VIC_CISR: rd = {30'h0, ~st.normReqN, ~st.fastReqN};
        VIC_SPU: rd = st.spu;
        VIC_DCR: rd = {30'h0, st.genMask, st.protect};
        VIC_FFSR: rd = st.ffsr;
        default: rd = '0;
      endcase
    end

    // Vector entry: save, select and clear the current source
    if (ivrAck && candFound) begin
      if (st.depth < 4'(VIC_STACK_DEPTH)) begin
        next_st.stack[st.depth[2:0]] = '{src: candSrc, prio: candPrio};  // [R22]
        next_st.depth = st.depth + 4'h1;
      end
      next_st.edgeLatch[candSrc] = 1'b0;  // [R21]
    end
    if (fvrAck) begin
      next_st.edgeLatch[VIC_SRC_FAST] = 1'b0;  // [R21]
    end

    if (doWrite) begin
      if (st.dpAddr < VIC_SVR_BASE) begin
        next_st.smr[slot].prio = hwdata[VIC_PRIO_LSB +: 3];
        next_st.smr[slot].trig = hwdata[VIC_TYPE_LSB +: 2];
      end else if (st.dpAddr < VIC_TABLE_END) begin
        next_st.svr[slot] = hwdata;  // [R11]
      end else begin
        unique case (st.dpAddr)
          VIC_IECR: next_st.imr = st.imr | hwdata;
          VIC_IDCR: next_st.imr = st.imr & ~hwdata;
          VIC_ICCR: next_st.edgeLatch = next_st.edgeLatch & ~hwdata;
          VIC_SPU: next_st.spu = hwdata;
          VIC_DCR: begin
            next_st.protect = hwdata[VIC_DCR_PROTECT];
            next_st.genMask = hwdata[VIC_DCR_GMASK];
          end
          VIC_FFER: next_st.ffsr = st.ffsr | (hwdata & ~32'h0000_0001);
          VIC_FFDR: next_st.ffsr = st.ffsr & ~hwdata;
          VIC_EOICR: begin
            if (inService) begin
              next_st.depth = st.depth - 4'h1;  // [R22]
            end
          end
          default: ;
        endcase
      end
    end

    // Set paths come last so a new event or a set beats any clear
    for (int i = 0; i < VIC_NSRC; i++) begin
      if (edgeMode[i] && cond[i] && !st.prevCond[i]) begin
        next_st.edgeLatch[i] = 1'b1;  // [R24] [R4] [R5]
      end
      if (edgeMode[i] && doWrite && vic_is(st.dpAddr, VIC_ISCR) && hwdata[i]) begin
        next_st.edgeLatch[i] = 1'b1;
      end
    end

    // Data phase tracking; a read holds one wait state
    if (doRead) begin
      next_st.rdata = rd;
      next_st.rdDone = 1'b1;
    end
    if (!st.dpValid || st.dpWrite || st.rdDone) begin
      next_st.dpValid = takeAddr;
      next_st.dpWrite = hwrite;
      next_st.dpAddr = haddr[11:0] & ((haddr[31:12] == 20'h0) ? 12'hFFF : 12'hFFC);
      next_st.rdDone = 1'b0;
      if (haddr[31:12] != 20'h0) begin
        next_st.dpAddr = 12'hFFC;
      end
    end

    // General mask keeps the lines quiet but still wakes the core
    next_st.normReqN = !(normalReq && !st.genMask);  // [R2] [R16] [R23]
    next_st.fastReqN = !(fastReq && !st.genMask);  // [R2] [R16] [R23]
    next_st.wake = normalReq || fastReq;  // [R15] [R16]
  end

  // ----------------------------------------------------------------
  // Registers (no clock gating anywhere)
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin  // [R14]
    if (!rstn) begin
      st <= '0;
      st.normReqN <= 1'b1;
      st.fastReqN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = !(st.dpValid && !st.dpWrite && !st.rdDone);
  assign hrdata = st.rdata;
  assign hresp = 1'b0;
  assign fastReqOutN = st.fastReqN;
  assign normalReqOutN = st.normReqN;
  assign wakeOut = st.wake;

endmodule // vectored_priority_interrupt_ctrl

/* File: vic_ctrl_sva.sv */
// Purpose: Port-level assertions for the vectored priority interrupt controller
// Assumes: One clock domain, AHB-Lite single word transfers
// Notes:   Requests stay idle until software has enabled some source
`timescale 1ns/1ps

module vic_ctrl_sva
  import vic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fastReqOutN,
  input wire logic normalReqOutN,
  input wire logic wakeOut
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic takeReq;
  logic enSeen;
  assign takeReq = hsel && htrans == VIC_HTRANS_NONSEQ && hready && hsize == VIC_HSIZE_WORD;
  // Reset masks every source, so nothing may request before an enable write
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) enSeen <= 1'b0;
    else if (takeReq && hwrite && haddr == 32'(VIC_IECR)) enSeen <= 1'b1;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("Response not OKAY");
  read_wait_a: assert property (takeReq && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("Read wait state wrong");
  single_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("Wait state too long");
  write_nowait_a: assert property (takeReq && hwrite |=> hreadyout)
    else $error("Write stalled");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("Read data moved outside a read");
  unmapped_zero_a: assert property (
    takeReq && !hwrite && haddr[31:12] != 20'h0 |=> ##1 hrdata == 32'h0)
    else $error("Unmapped read not zero");
  wake_follow_a: assert property (!fastReqOutN || !normalReqOutN |-> wakeOut)
    else $error("Request without wake");
  masked_quiet_a: assert property (!enSeen |-> fastReqOutN && normalReqOutN && !wakeOut)
    else $error("Request while all masked");
endmodule // vic_ctrl_sva

bind vectored_priority_interrupt_ctrl vic_ctrl_sva sva (.sys_clk(sys_clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .fastReqOutN(fastReqOutN), .normalReqOutN(normalReqOutN), .wakeOut(wakeOut));

/* File: vic_core_model.sv */
// Purpose: Processor core and interrupt source lines facing the controller
// Assumes: Lines change just after a rising clock edge
// Notes:   The core sleeps on command and any request line wakes it
`timescale 1ns/1ps

module vic_core_model
  import vic_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic fastReqOutN,
  input wire logic normalReqOutN,
  input wire logic sleepReq,
  output logic awake,
  output logic fastIntPin,
  output logic systemSource,
  output logic [VIC_PERIPH_HI:2] peripheralSourceIds,
  output logic [2:0] extIntPins
);
  // ----------------------------------------------------------------
  // Source lines, indexed by source number
  // ----------------------------------------------------------------
  logic [31:0] line = 32'h0;
  assign fastIntPin = line[0];
  assign systemSource = line[1];
  assign peripheralSourceIds = line[VIC_PERIPH_HI:2];
  assign extIntPins = line[31:29];
  task automatic drive(input int n, input logic v);
    line[n] <= v;
  endtask
  // Idle core leaves idle on either request, never later
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) awake <= 1'b1;
    else if (!fastReqOutN || !normalReqOutN) awake <= 1'b1;
    else if (sleepReq) awake <= 1'b0;
endmodule // vic_core_model

/* File: vectored_priority_interrupt_ctrl_tb.sv */
// Purpose: Self-checking bench for the vectored priority interrupt controller
// Assumes: AHB-Lite master with single word transfers, 10 MHz clock
// Notes:   Pins are left four cycles to pass their synchronisers
`timescale 1ns/1ps

module vectored_priority_interrupt_ctrl_tb
  import vic_pkg::*;
;
  logic sys_clk, rstn, hsel, hwrite, sleepReq;
  logic [31:0] haddr, hwdata, rdVal;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [19:0] hiAddr;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, fastReqOutN, normalReqOutN, wakeOut, awake;
  wire logic fastIntPin, systemSource;
  wire logic [VIC_PERIPH_HI:2] peripheralSourceIds;
  wire logic [2:0] extIntPins;
  int fail_count, n_checks, cycles;
  typedef struct {logic [4:0] src; logic [1:0] trig; logic idle;} vic_row_t;
  vic_row_t rows[6] = '{'{5'h01, 2'h2, 1'b0}, '{5'h05, 2'h1, 1'b0}, '{5'h1D, 2'h3, 1'b0},
    '{5'h1E, 2'h1, 1'b1}, '{5'h1F, 2'h2, 1'b0}, '{5'h1D, 2'h0, 1'b1}};

  vectored_priority_interrupt_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fastIntPin(fastIntPin), .systemSource(systemSource),
    .peripheralSourceIds(peripheralSourceIds), .extIntPins(extIntPins),
    .fastReqOutN(fastReqOutN), .normalReqOutN(normalReqOutN), .wakeOut(wakeOut));
  vic_core_model core (.sys_clk(sys_clk), .rstn(rstn), .fastReqOutN(fastReqOutN),
    .normalReqOutN(normalReqOutN), .sleepReq(sleepReq), .awake(awake),
    .fastIntPin(fastIntPin), .systemSource(systemSource),
    .peripheralSourceIds(peripheralSourceIds), .extIntPins(extIntPins));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hsel stays high so back-to-back calls never assign it twice in one step
  task automatic bus(input logic wrt, input logic [11:0] off, input logic [31:0] d);
    htrans <= VIC_HTRANS_NONSEQ;
    haddr <= {hiAddr, off};
    hwrite <= wrt;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdVal = hrdata;
  endtask
  task automatic waitReq(input logic f, input logic v);
    for (int i = 0; i < 12 && ((f ? fastReqOutN : normalReqOutN) !== v); i++)
      @(posedge sys_clk);
  endtask
  function automatic logic [31:0] vec(input int s);
    return 32'hA000_0000 | 32'(s);
  endfunction

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, hwrite, sleepReq, haddr, hwdata, hiAddr} = '0;
    {fail_count, n_checks, cycles} = '0;
    hsel = 1'b1;
    htrans = 2'h0;
    hsize = VIC_HSIZE_WORD;
    repeat (2) @(posedge sys_clk);
    chk("reset request", {fastReqOutN, normalReqOutN, wakeOut, hreadyout}, 32'hD);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (rows[k]) begin
      core.drive(rows[k].src, rows[k].idle);
      repeat (4) @(posedge sys_clk);
      bus(1, VIC_ICCR, 32'h1 << rows[k].src);
      bus(1, VIC_SMR_BASE + 12'(4 * rows[k].src), {25'h0, rows[k].trig, 5'h03});
      bus(1, VIC_SVR_BASE + 12'(4 * rows[k].src), vec(rows[k].src));
      bus(1, VIC_IECR, 32'h1 << rows[k].src);
      core.drive(rows[k].src, ~rows[k].idle);
      waitReq(0, 0);
      chk("request", {normalReqOutN, wakeOut}, 32'h1);
      bus(0, VIC_IVR, 32'h0);
      chk("vector", rdVal, vec(rows[k].src));
      bus(0, VIC_ISR, 32'h0);
      chk("current", rdVal, 32'(rows[k].src));
      core.drive(rows[k].src, rows[k].idle);
      bus(1, VIC_EOICR, 32'h0);
      waitReq(0, 1);
      chk("released", 32'(normalReqOutN), 32'h1);
      bus(1, VIC_IDCR, 32'h1 << rows[k].src);
      $display("Row %0d done", k);
    end
    for (int s = 6; s < 9; s++) begin
      bus(1, VIC_SMR_BASE + 12'(4 * s), (s == 8) ? 32'h25 : 32'h22);
      bus(1, VIC_SVR_BASE + 12'(4 * s), vec(s));
    end
    bus(1, VIC_IECR, 32'h1C0);
    bus(1, VIC_ISCR, 32'hC0);
    waitReq(0, 0);
    bus(0, VIC_IVR, 32'h0);
    chk("tie", rdVal, vec(6));
    waitReq(0, 1);
    chk("same level", 32'(normalReqOutN), 32'h1);
    bus(1, VIC_ISCR, 32'h100);
    waitReq(0, 0);
    chk("preempt", 32'(normalReqOutN), 32'h0);
    bus(0, VIC_IVR, 32'h0);
    chk("high first", rdVal, vec(8));
    bus(1, VIC_EOICR, 32'h0);
    waitReq(0, 1);
    chk("pop", 32'(normalReqOutN), 32'h1);
    bus(1, VIC_EOICR, 32'h0);
    waitReq(0, 0);
    chk("pop empty", 32'(normalReqOutN), 32'h0);
    bus(0, VIC_IVR, 32'h0);
    chk("next tie", rdVal, vec(7));
    bus(1, VIC_EOICR, 32'h0);
    $display("Nesting done");
    bus(1, VIC_DCR, 32'h1);
    bus(1, VIC_ISCR, 32'h40);
    bus(0, VIC_IVR, 32'h0);
    chk("protect", {rdVal[3:0], normalReqOutN}, 32'hC);
    bus(1, VIC_DCR, 32'h2);
    // The mask lands at the data-phase edge; the line follows one edge later
    waitReq(0, 1);
    chk("gen mask", {normalReqOutN, wakeOut}, 32'h3);
    bus(1, VIC_DCR, 32'h0);
    bus(0, VIC_IVR, 32'h0);
    bus(1, VIC_EOICR, 32'h0);
    waitReq(0, 1);
    chk("auto clear", 32'(normalReqOutN), 32'h1);
    bus(1, VIC_FFER, 32'h40);
    bus(1, VIC_ISCR, 32'h40);
    waitReq(1, 0);
    bus(0, VIC_IVR, 32'h0);
    chk("forced", {fastReqOutN, normalReqOutN}, 32'h1);
    bus(1, VIC_ICCR, 32'h40);
    bus(1, VIC_FFDR, 32'h40);
    $display("Modes done");
    bus(1, VIC_SMR_BASE, 32'h60);
    bus(1, VIC_SVR_BASE, vec(0));
    bus(1, VIC_IECR, 32'h1);
    sleepReq <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sleepReq <= 1'b0;
    chk("asleep", 32'(awake), 32'h0);
    core.drive(0, 1'b1);
    waitReq(1, 0);
    // The core wakes on the edge that first sees the request low
    @(posedge sys_clk);
    chk("fast pin", {fastReqOutN, normalReqOutN, awake}, 32'h3);
    core.drive(0, 1'b0);
    bus(0, VIC_FVR, 32'h0);
    chk("fast vector", rdVal, vec(0));
    waitReq(1, 1);
    chk("fast clear", 32'(fastReqOutN), 32'h1);
    hiAddr = 20'h1;
    bus(0, VIC_IVR, 32'h0);
    chk("unmapped", rdVal, 32'h0);
    hiAddr = 20'h0;
    $display("Fast and bus done");
    close_out();
  end
endmodule // vectored_priority_interrupt_ctrl_tb
